// [hw/xbar_pkg.sv]
package xbar_pkg;

    // ----------------------------------------------------------------
    // Ports and channels
    // ----------------------------------------------------------------
    localparam int NUM_PORTS = 5;
    localparam int NUM_LINKS = 3;
    localparam int NUM_VC    = 4;
    localparam int PORT_SRI  = 3;
    localparam int PORT_MCT  = 4;
    localparam int CNT_W     = 4;
    localparam int USE_W     = 7;

    typedef enum logic [1:0] {VC_REQ, VC_POSTED, VC_RSP, VC_PROBE} vc_e;

    // Credit counter indices: port*4+vc, then extras
    localparam int IDX_DOWN_REQ  = 20;
    localparam int IDX_DOWN_POSTED_REQUEST_CHANNEL_BUFFER = 21;
    localparam int IDX_POOL      = 22;
    localparam int IDX_DATA0     = 23;
    localparam int NUM_CNT       = 28;

    // Buffers in use across all inputs at once
    localparam logic [6:0] CMD_IN_USE_MAX = 7'h40;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W     = 12;
    localparam logic [11:0] OFF_SRI    = 12'h070;
    localparam logic [11:0] OFF_MCT    = 12'h078;
    localparam logic [11:0] OFF_POOL   = 12'h07c;
    localparam logic [11:0] OFF_STATUS = 12'h080;
    localparam logic [11:0] OFF_LINK0  = 12'h090;
    localparam logic [11:0] OFF_LINK1  = 12'h0b0;
    localparam logic [11:0] OFF_LINK2  = 12'h0d0;

    // Link and memory controller layout: four 4-bit counts, one per channel, then data count
    localparam int LF_REQ  = 0;
    localparam int LF_POSTED_REQUEST_CHANNEL_BUFFER = 4;
    localparam int LF_RSP  = 8;
    localparam int LF_PRB  = 12;
    localparam int LF_DATA = 16;
    localparam logic [31:0] LINK_MASK   = 32'h000f_ffff;
    localparam logic [31:0] LINK_COH_RST = 32'h0008_5613;
    localparam logic [31:0] LINK_NC_DEF  = 32'h0008_0456;
    localparam logic [31:0] MCT_RST      = 32'h0008_3800;

    // Request interface layout (2-bit fields)
    localparam int SF_UREQ    = 0;
    localparam int SF_UPREQ   = 4;
    localparam int SF_URSP    = 8;
    localparam int SF_REQD    = 16;
    localparam int SF_DISPREF = 20;
    localparam int SF_URSPD   = 24;
    localparam int SF_DREQ    = 28;
    localparam int SF_DPREQ   = 30;
    localparam logic [31:0] SRI_MASK = 32'hf333_0333;
    localparam logic [31:0] SRI_RST  = 32'h5102_0111;

    // Shared pool layout
    localparam int PF_REQ = 0;
    localparam int PF_RSP = 4;
    localparam logic [31:0] POOL_MASK = 32'h0000_0033;
    localparam logic [31:0] POOL_RST  = 32'h0000_0021;

    // Status layout
    localparam int ST_USED    = 0;
    localparam int ST_PRESENT = 8;
    localparam int ST_LOADED  = 16;

endpackage

// [hw/credit_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module credit_counter
    import xbar_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         take,
    input  wire logic         give,
    output var  logic [W-1:0] cnt,
    output var  logic         avail,
    output var  logic         full
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] lim;
    } cred_s;

    cred_s s_ff;
    cred_s nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        if (load)
        begin
            nxt_s.cnt = load_val;
            nxt_s.lim = load_val;
        end
        else
        begin
            if (take && (s_ff.cnt != '0))
                nxt_s.cnt = s_ff.cnt - 1'b1;
            // Returns beyond the allocation are dropped
            if (give && (nxt_s.cnt < s_ff.lim))
                nxt_s.cnt = nxt_s.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign cnt   = s_ff.cnt;
    assign avail = (s_ff.cnt != '0);
    assign full  = (s_ff.cnt == s_ff.lim);

endmodule

`default_nettype wire

// [hw/xbar_switch.sv]
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module xbar_switch
    import xbar_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   warm_reset,
    input  wire logic [NUM_LINKS-1:0]   link_present,
    input  wire logic [NUM_LINKS-1:0]   link_coherent,
    input  wire logic [NUM_PORTS-1:0]   req_valid,
    input  wire logic [2*NUM_PORTS-1:0] req_vc,
    input  wire logic [NUM_PORTS-1:0]   req_dir,
    input  wire logic [3*NUM_PORTS-1:0] req_dest,
    input  wire logic [NUM_PORTS-1:0]   req_data,
    output var  logic [NUM_PORTS-1:0]   req_grant,
    output var  logic [NUM_PORTS-1:0]   fwd_valid,
    output var  logic [3*NUM_PORTS-1:0] fwd_src,
    output var  logic [2*NUM_PORTS-1:0] fwd_vc,
    output var  logic [NUM_PORTS-1:0]   fwd_data,
    input  wire logic [NUM_PORTS-1:0]   rel_valid,
    input  wire logic [2*NUM_PORTS-1:0] rel_vc,
    input  wire logic [NUM_PORTS-1:0]   rel_dir,
    input  wire logic [NUM_PORTS-1:0]   rel_data,
    output var  logic [USE_W-1:0]       cmd_in_use
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_LINKS-1:0][31:0] link_cfg;
        logic [31:0]                sri_cfg;
        logic [31:0]                pool_cfg;
        logic [31:0]                mct_cfg;
        logic [NUM_LINKS-1:0]       prog;
        logic [NUM_LINKS-1:0]       present;
        logic                       loaded;
        logic [USE_W-1:0]           used;
        logic [2:0]                 rr;
        logic [NUM_PORTS-1:0]       grant;
        logic [NUM_PORTS-1:0]       fwd_valid;
        logic [3*NUM_PORTS-1:0]     fwd_src;
        logic [2*NUM_PORTS-1:0]     fwd_vc;
        logic [NUM_PORTS-1:0]       fwd_data;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
    } sw_s;

    localparam sw_s SW_RST = '{
        link_cfg : {LINK_COH_RST, LINK_COH_RST, LINK_COH_RST},
        sri_cfg  : SRI_RST,
        pool_cfg : POOL_RST,
        mct_cfg  : MCT_RST,
        default  : '0
    };

    sw_s s_ff;
    sw_s nxt_s;

    logic [NUM_CNT-1:0]            take;
    logic [NUM_CNT-1:0]            give;
    logic [NUM_CNT-1:0][CNT_W-1:0] load_val;
    logic [NUM_CNT-1:0]            cnt_avail;
    logic [NUM_CNT-1:0]            cnt_full;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] apb_merge(input logic [31:0] old_v,
                                               input logic [31:0] wd,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = wd[8*b +: 8];
        end
        return r & mask;
    endfunction

    // Credit slot for a packet; -1 when the channel has no counter
    function automatic int cmd_idx(input int p, input logic [1:0] vc, input logic dir);
        if ((p == PORT_SRI) && dir)
        begin
            if (vc == VC_REQ)
                return IDX_DOWN_REQ;
            else if (vc == VC_POSTED)
                return IDX_DOWN_POSTED_REQUEST_CHANNEL_BUFFER;
            else
                return -1;
        end
        return p * NUM_VC + int'(vc);
    endfunction

    function automatic logic port_on(input int p, input logic [NUM_LINKS-1:0] pres);
        if (p >= NUM_LINKS)
            return 1'b1;
        return pres[p];
    endfunction

    // ----------------------------------------------------------------
    // Credit counters
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_CNT; g++)
        begin : g_cnt
            credit_counter #(.W(CNT_W)) u_cnt
            (
                .pclk     (pclk),
                .presetn  (presetn),
                .load     (warm_reset),
                .load_val (load_val[g]),
                .take     (take[g]),
                .give     (give[g]),
                .cnt      (),
                .avail    (cnt_avail[g]),
                .full     (cnt_full[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [31:0]          eff;
        logic [31:0]          rd;
        logic                 hit;
        logic [USE_W-1:0]     used_v;
        logic [USE_W-1:0]     rel_n;
        logic [NUM_PORTS-1:0] dest_busy;
        logic [1:0]           vc;
        logic [2:0]           dst;
        logic                 ok;
        logic                 use_pool;
        int                   p;
        int                   ci;
        eff       = '0;
        rd        = '0;
        hit       = 1'b0;
        used_v    = s_ff.used;
        rel_n     = '0;
        dest_busy = '0;
        vc        = '0;
        dst       = '0;
        ok        = 1'b0;
        use_pool  = 1'b0;
        p         = 0;
        ci        = 0;
        nxt_s     = s_ff;
        take      = '0;
        give      = '0;
        load_val  = '0;

        // Allocation loaded at warm reset only, from the registers, or LINK_NC_DEF for a non-coherent link never written, or zero for an absent link
        for (int l = 0; l < NUM_LINKS; l++)
        begin
            eff = (s_ff.prog[l] || link_coherent[l]) ? s_ff.link_cfg[l] : LINK_NC_DEF;
            if (!link_present[l])
                eff = '0;
            load_val[l*NUM_VC + VC_REQ]    = eff[LF_REQ  +: CNT_W];
            load_val[l*NUM_VC + VC_POSTED] = eff[LF_POSTED_REQUEST_CHANNEL_BUFFER +: CNT_W];
            load_val[l*NUM_VC + VC_RSP]    = eff[LF_RSP  +: CNT_W];
            load_val[l*NUM_VC + VC_PROBE]  = eff[LF_PRB  +: CNT_W];
            load_val[IDX_DATA0 + l]        = eff[LF_DATA +: CNT_W];
        end
        load_val[PORT_MCT*NUM_VC + VC_REQ]    = s_ff.mct_cfg[LF_REQ  +: CNT_W];
        load_val[PORT_MCT*NUM_VC + VC_POSTED] = s_ff.mct_cfg[LF_POSTED_REQUEST_CHANNEL_BUFFER +: CNT_W];
        load_val[PORT_MCT*NUM_VC + VC_RSP]    = s_ff.mct_cfg[LF_RSP  +: CNT_W];
        load_val[PORT_MCT*NUM_VC + VC_PROBE]  = s_ff.mct_cfg[LF_PRB  +: CNT_W];
        load_val[IDX_DATA0 + PORT_MCT]        = s_ff.mct_cfg[LF_DATA +: CNT_W];
        // Upstream and downstream kept apart
        load_val[PORT_SRI*NUM_VC + VC_REQ]    = {2'b00, s_ff.sri_cfg[SF_UREQ  +: 2]};
        load_val[PORT_SRI*NUM_VC + VC_POSTED] = {2'b00, s_ff.sri_cfg[SF_UPREQ +: 2]};
        load_val[PORT_SRI*NUM_VC + VC_RSP]    = {2'b00, s_ff.sri_cfg[SF_URSP  +: 2]};
        load_val[IDX_DOWN_REQ]  = {2'b00, s_ff.sri_cfg[SF_DREQ  +: 2]};
        load_val[IDX_DOWN_POSTED_REQUEST_CHANNEL_BUFFER] = {2'b00, s_ff.sri_cfg[SF_DPREQ +: 2]};
        load_val[IDX_POOL]      = {2'b00, s_ff.pool_cfg[PF_REQ +: 2]}
                                + {2'b00, s_ff.pool_cfg[PF_RSP +: 2]};
        load_val[IDX_DATA0 + PORT_SRI] = {2'b00, s_ff.sri_cfg[SF_REQD  +: 2]}
                                       + {2'b00, s_ff.sri_cfg[SF_URSPD +: 2]};

        // APB slave, no wait states
        nxt_s.pready  = psel && !penable;
        nxt_s.pslverr = 1'b0;
        case (paddr)
            OFF_LINK0:  begin rd = s_ff.link_cfg[0]; hit = 1'b1; end
            OFF_LINK1:  begin rd = s_ff.link_cfg[1]; hit = 1'b1; end
            OFF_LINK2:  begin rd = s_ff.link_cfg[2]; hit = 1'b1; end
            OFF_SRI:    begin rd = s_ff.sri_cfg;     hit = 1'b1; end
            OFF_POOL:   begin rd = s_ff.pool_cfg;    hit = 1'b1; end
            OFF_MCT:    begin rd = s_ff.mct_cfg;     hit = 1'b1; end
            OFF_STATUS:
            begin
                rd[ST_USED +: USE_W]        = s_ff.used;
                rd[ST_PRESENT +: NUM_LINKS] = s_ff.present;
                rd[ST_LOADED]               = s_ff.loaded;
                hit                         = 1'b1;
            end
            default:    begin rd = '0; hit = 1'b0; end
        endcase
        if (psel && !penable)
        begin
            nxt_s.prdata  = pwrite ? '0 : rd;
            nxt_s.pslverr = !hit;
        end
        if (psel && penable && s_ff.pready && pwrite)
        begin
            // Stored only; counters see it at the next warm reset
            case (paddr)
                OFF_LINK0:
                begin
                    nxt_s.link_cfg[0] = apb_merge(s_ff.link_cfg[0], pwdata, pstrb, LINK_MASK);
                    nxt_s.prog[0]     = 1'b1;
                end
                OFF_LINK1:
                begin
                    nxt_s.link_cfg[1] = apb_merge(s_ff.link_cfg[1], pwdata, pstrb, LINK_MASK);
                    nxt_s.prog[1]     = 1'b1;
                end
                OFF_LINK2:
                begin
                    nxt_s.link_cfg[2] = apb_merge(s_ff.link_cfg[2], pwdata, pstrb, LINK_MASK);
                    nxt_s.prog[2]     = 1'b1;
                end
                OFF_SRI:  nxt_s.sri_cfg  = apb_merge(s_ff.sri_cfg, pwdata, pstrb, SRI_MASK);
                OFF_POOL: nxt_s.pool_cfg = apb_merge(s_ff.pool_cfg, pwdata, pstrb, POOL_MASK);
                OFF_MCT:  nxt_s.mct_cfg  = apb_merge(s_ff.mct_cfg, pwdata, pstrb, LINK_MASK);
                default:  nxt_s.prog = s_ff.prog;
            endcase
        end

        // Switching
        nxt_s.grant     = '0;
        nxt_s.fwd_valid = '0;
        nxt_s.rr        = (s_ff.rr == 3'(NUM_PORTS - 1)) ? 3'h0 : s_ff.rr + 3'h1;
        if (warm_reset)
        begin
            nxt_s.used    = '0;
            nxt_s.present = link_present;
            nxt_s.loaded  = 1'b1;
        end
        else if (s_ff.loaded)
        begin
            for (int k = 0; k < NUM_PORTS; k++)
            begin
                p        = (int'(s_ff.rr) + k) % NUM_PORTS;
                vc       = req_vc[2*p +: 2];
                dst      = req_dest[3*p +: 3];
                ci       = cmd_idx(p, vc, req_dir[p]);
                use_pool = 1'b0;
                ok = req_valid[p] && !s_ff.grant[p] && port_on(p, s_ff.present)
                     && (dst < 3'(NUM_PORTS)) && (ci >= 0);
                if (ok)
                    ok = port_on(int'(dst), s_ff.present) && !dest_busy[dst];
                if (used_v >= CMD_IN_USE_MAX)
                    ok = 1'b0;
                if (ok && !cnt_avail[ci])
                begin
                    if ((p == PORT_SRI) && (vc != VC_PROBE) && cnt_avail[IDX_POOL])
                        use_pool = 1'b1;
                    else
                        ok = 1'b0;
                end
                // Data credits per input only, no shared cap
                if (ok && req_data[p] && !cnt_avail[IDX_DATA0 + p])
                    ok = 1'b0;
                if (ok)
                begin
                    take[use_pool ? IDX_POOL : ci] = 1'b1;
                    if (req_data[p])
                        take[IDX_DATA0 + p] = 1'b1;
                    used_v                     = used_v + 7'h01;
                    dest_busy[dst]             = 1'b1;
                    nxt_s.grant[p]             = 1'b1;
                    nxt_s.fwd_valid[dst]       = 1'b1;
                    nxt_s.fwd_src[3*dst +: 3]  = 3'(p);
                    nxt_s.fwd_vc[2*dst +: 2]   = vc;
                    nxt_s.fwd_data[dst]        = req_data[p];
                end
            end
            for (int r = 0; r < NUM_PORTS; r++)
            begin
                ci = cmd_idx(r, rel_vc[2*r +: 2], rel_dir[r]);
                if (rel_valid[r] && (ci >= 0))
                begin
                    // Dedicated slot refilled first, overflow back to the pool
                    if ((r == PORT_SRI) && cnt_full[ci])
                        give[IDX_POOL] = 1'b1;
                    else
                        give[ci] = 1'b1;
                    rel_n = rel_n + 7'h01;
                end
                if (rel_data[r])
                    give[IDX_DATA0 + r] = 1'b1;
            end
            nxt_s.used = (used_v >= rel_n) ? used_v - rel_n : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_ff <= SW_RST;
        else
            s_ff <= nxt_s;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata     = s_ff.prdata;
    assign pready     = s_ff.pready;
    assign pslverr    = s_ff.pslverr;
    assign req_grant  = s_ff.grant;
    assign fwd_valid  = s_ff.fwd_valid;
    assign fwd_src    = s_ff.fwd_src;
    assign fwd_vc     = s_ff.fwd_vc;
    assign fwd_data   = s_ff.fwd_data;
    assign cmd_in_use = s_ff.used;

endmodule

`default_nettype wire

// [verification/xbar_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module xbar_checker
    import xbar_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   warm_reset,
    input wire logic [NUM_PORTS-1:0]   req_valid,
    input wire logic [2*NUM_PORTS-1:0] req_vc,
    input wire logic [NUM_PORTS-1:0]   req_grant,
    input wire logic [NUM_PORTS-1:0]   fwd_valid,
    input wire logic [USE_W-1:0]       cmd_in_use
);
    // --------
    // Warm reset seen since power-on reset
    // --------
    logic seen_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_ff <= 1'b0;
        else if (warm_reset)
            seen_ff <= 1'b1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_ctx: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_ctx: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_grant_cause: assert property (req_grant != 5'h00 |-> ($past(req_valid) & req_grant) == req_grant)
        else $error("grant without request");
    chk_grant_pulse: assert property ((req_grant & $past(req_grant)) == 5'h00)
        else $error("grant longer than one cycle");
    chk_fwd_pairs: assert property ($countones(fwd_valid) == $countones(req_grant))
        else $error("forward count differs from grants");
    chk_use_cap: assert property (cmd_in_use <= CMD_IN_USE_MAX)
        else $error("more than 64 buffers in use");
    chk_warm_clear: assert property (warm_reset |=> cmd_in_use == 7'h00)
        else $error("use count not cleared by warm reset");
    chk_loaded_first: assert property (req_grant != 5'h00 |-> seen_ff)
        else $error("grant before warm reset");
    chk_memctl_vc: assert property (req_grant[4] |-> $past(req_vc[9]))
        else $error("memory controller granted on empty channel");
    cover property (req_grant[0]);
    cover property (pslverr);
    cover property (cmd_in_use == 7'h05);
endmodule
bind xbar_switch xbar_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .warm_reset(warm_reset),
    .req_valid(req_valid), .req_vc(req_vc), .req_grant(req_grant),
    .fwd_valid(fwd_valid), .cmd_in_use(cmd_in_use));
`default_nettype wire

// [verification/link_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module link_peer
    import xbar_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic [NUM_PORTS-1:0]   req_grant,
    input  wire logic [NUM_PORTS-1:0]   fwd_valid,
    input  wire logic [3*NUM_PORTS-1:0] fwd_src,
    output var  logic [NUM_PORTS-1:0]   req_valid = '0,
    output var  logic [2*NUM_PORTS-1:0] req_vc = '0,
    output var  logic [NUM_PORTS-1:0]   req_dir = '0,
    output var  logic [3*NUM_PORTS-1:0] req_dest = '0,
    output var  logic [NUM_PORTS-1:0]   req_data = '0,
    output var  logic [NUM_PORTS-1:0]   rel_valid = '0,
    output var  logic [2*NUM_PORTS-1:0] rel_vc = '0,
    output var  logic [NUM_PORTS-1:0]   rel_dir = '0,
    output var  logic [NUM_PORTS-1:0]   rel_data = '0
);
    // --------
    // Packet send, held until grant or give-up
    // --------
    task automatic send(input int p, input logic [1:0] v, input logic [2:0] d,
                        output logic ok);
        logic g;
        g = 1'b0;
        ok = 1'b0;
        @(posedge pclk);
        req_valid[p] <= 1'b1;
        req_vc[2*p +: 2] <= v;
        req_dest[3*p +: 3] <= d;
        for (int i = 0; i < 8 && !g; i++)
        begin
            @(negedge pclk);
            g = (req_grant[p] === 1'b1);
            ok = g && fwd_valid[d] === 1'b1 && fwd_src[3*d +: 3] === p[2:0];
        end
        @(posedge pclk);
        req_valid[p] <= 1'b0;
        req_vc[2*p +: 2] <= ~v;
        req_dest[3*p +: 3] <= ~d;
    endtask
    task automatic free_buf(input int p, input logic [1:0] v);
        @(posedge pclk);
        rel_valid[p] <= 1'b1;
        rel_vc[2*p +: 2] <= v;
        @(posedge pclk);
        rel_valid[p] <= 1'b0;
        rel_vc[2*p +: 2] <= ~v;
    endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
    import xbar_pkg::*;
;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic [11:0]            paddr = '0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [31:0]            pwdata = '0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   warm_reset = 1'b0;
    logic [NUM_LINKS-1:0]   link_present = 3'h7;
    logic [NUM_LINKS-1:0]   link_coherent = 3'h3;
    logic [NUM_PORTS-1:0]   req_valid, req_dir, req_data, req_grant;
    logic [NUM_PORTS-1:0]   fwd_valid, fwd_data, rel_valid, rel_dir, rel_data;
    logic [2*NUM_PORTS-1:0] req_vc, fwd_vc, rel_vc;
    logic [3*NUM_PORTS-1:0] req_dest, fwd_src;
    logic [USE_W-1:0]       cmd_in_use;
    logic                   ok;
    int                     miscompares = 0;
    int                     cmp_count = 0;

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    xbar_switch dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .warm_reset(warm_reset),
        .link_present(link_present), .link_coherent(link_coherent),
        .req_valid(req_valid), .req_vc(req_vc), .req_dir(req_dir), .req_dest(req_dest),
        .req_data(req_data), .req_grant(req_grant), .fwd_valid(fwd_valid),
        .fwd_src(fwd_src), .fwd_vc(fwd_vc), .fwd_data(fwd_data), .rel_valid(rel_valid),
        .rel_vc(rel_vc), .rel_dir(rel_dir), .rel_data(rel_data), .cmd_in_use(cmd_in_use));
    link_peer peer (.pclk(pclk), .req_grant(req_grant), .fwd_valid(fwd_valid),
        .fwd_src(fwd_src), .req_valid(req_valid), .req_vc(req_vc), .req_dir(req_dir),
        .req_dest(req_dest), .req_data(req_data), .rel_valid(rel_valid),
        .rel_vc(rel_vc), .rel_dir(rel_dir), .rel_data(rel_data));

    // --------
    // Shared tasks
    // --------
    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            miscompares++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check("read data", exp, r);
        check("slave error", {31'h0, err}, {31'h0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic warm();
        @(posedge pclk);
        warm_reset <= 1'b1;
        @(posedge pclk);
        warm_reset <= 1'b0;
    endtask
    task automatic send_chk(input int p, input logic [1:0] v, input logic [31:0] exp);
        peer.send(p, v, 3'h4, ok);
        check("grant", exp, {31'h0, ok});
        if (exp[0])
            check("forward", {29'h0, v, 1'b0}, {29'h0, fwd_vc[9:8], fwd_data[4]});
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_regs();
        rd_chk(OFF_LINK0, LINK_COH_RST, 1'b0);
        rd_chk(OFF_MCT, MCT_RST, 1'b0);
        rd_chk(OFF_SRI, SRI_RST, 1'b0);
        rd_chk(OFF_POOL, POOL_RST, 1'b0);
        rd_chk(12'h004, 32'h0, 1'b1);
        wr(OFF_POOL, 32'hffff_ffff);
        rd_chk(OFF_POOL, POOL_MASK, 1'b0);
        wr(OFF_POOL, POOL_RST);
    endtask
    task automatic t_links();
        for (int i = 0; i < 5; i++)
            send_chk(0, VC_PROBE, 1);
        send_chk(0, VC_PROBE, 0);
        @(negedge pclk);
        check("in use", 5, {25'h0, cmd_in_use});
        peer.free_buf(0, VC_PROBE);
        send_chk(0, VC_PROBE, 1);
        for (int i = 0; i < 5; i++)
            peer.free_buf(0, VC_PROBE);
        send_chk(2, VC_PROBE, 0);
        send_chk(2, VC_REQ, 1);
        peer.free_buf(2, VC_REQ);
        send_chk(4, VC_REQ, 0);
        send_chk(4, VC_RSP, 1);
        peer.free_buf(4, VC_RSP);
    endtask
    task automatic t_pool();
        for (int i = 0; i < 4; i++)
            send_chk(3, VC_REQ, 1);
        send_chk(3, VC_REQ, 0);
        for (int i = 0; i < 4; i++)
            peer.free_buf(3, VC_REQ);
        @(negedge pclk);
        check("in use", 0, {25'h0, cmd_in_use});
    endtask
    task automatic t_defer();
        wr(OFF_LINK1, 32'h0008_0f00);
        send_chk(1, VC_REQ, 1);
        peer.free_buf(1, VC_REQ);
        warm();
        send_chk(1, VC_REQ, 0);
        send_chk(1, VC_RSP, 1);
        link_present <= 3'h6;
        warm();
        send_chk(0, VC_PROBE, 0);
        rd_chk(OFF_STATUS, 32'h0001_0600, 1'b0);
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        send_chk(0, VC_PROBE, 0);
        warm();
        t_links();
        t_pool();
        t_defer();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
